// ---- iag_defines.svh ----
/*
  Constants of the indirect address generator: register offsets, field positions,
  reset values and limits.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef IAG_DEFINES_SVH
`define IAG_DEFINES_SVH

// ==========================================================================
// Special function register map (12-bit data addresses)
`define IAG_ADDR_PLUSW0   12'h0_FEB
`define IAG_ADDR_PREINC0  12'h0_FEC
`define IAG_ADDR_POSTDEC0 12'h0_FED
`define IAG_ADDR_POSTINC0 12'h0_FEE
`define IAG_ADDR_INDIR0   12'h0_FEF
`define IAG_ADDR_PTR0L    12'h0_FE9
`define IAG_ADDR_PTR0H    12'h0_FEA
`define IAG_ADDR_PLUSW1   12'h0_FE3
`define IAG_ADDR_PREINC1  12'h0_FE4
`define IAG_ADDR_POSTDEC1 12'h0_FE5
`define IAG_ADDR_POSTINC1 12'h0_FE6
`define IAG_ADDR_INDIR1   12'h0_FE7
`define IAG_ADDR_PTR1L    12'h0_FE1
`define IAG_ADDR_PTR1H    12'h0_FE2
`define IAG_ADDR_PLUSW2   12'h0_FDB
`define IAG_ADDR_PREINC2  12'h0_FDC
`define IAG_ADDR_POST_DECREMENT_TWO 12'h0_FDD
`define IAG_ADDR_POSTINC2 12'h0_FDE
`define IAG_ADDR_INDIR2   12'h0_FDF
`define IAG_ADDR_PTR2L    12'h0_FD9
`define IAG_ADDR_PTR2H    12'h0_FDA
// Each pair's operand block spans base..base+4, pairs 8 apart
`define IAG_OPND_SPAN     12'h0_008
`define IAG_HIGH_MASK     8'h0F
// Access bank and literal offset limits
`define IAG_LIT_LIMIT     8'h5F
`define IAG_ACCESS_SFR    12'h0_F00
`define IAG_ACCESS_SPLIT  8'h60
`define IAG_ZERO_BYTE     8'h00
`define IAG_PTR_RESET     12'h0_000
`define IAG_ONE           12'h0_001
// APB register offsets (byte addresses)
`define IAG_REG_ACCESS    12'h0_000
`define IAG_REG_CONFIG    12'h0_004
`define IAG_REG_WREG      12'h0_008
`define IAG_REG_BANK      12'h0_00C
`define IAG_REG_PTR0      12'h0_010
`define IAG_REG_PTR1      12'h0_014
`define IAG_REG_PTR2      12'h0_018
`define IAG_REG_RESULT    12'h0_01C
`define IAG_REG_STATUS    12'h0_020
`define IAG_REG_OPCODE    12'h0_024
// Field positions
`define IAG_ACC_WR_BIT    8
`define IAG_ACC_A_BIT     9
`define IAG_ACC_GO_BIT    10
`define IAG_CFG_EXTENDED_SET_ENABLE_BIT 0

`endif

// ---- iag_pkg.sv ----
/*
  Types of the indirect address generator.
  Assumes iag_defines.svh sits in the include path.
*/
package iag_pkg;
  `include "iag_defines.svh"

  // ==========================================================================
  // Operand kinds of a pointer pair
  typedef enum logic [2:0] {
    IAG_OP_NONE,
    IAG_OP_PLAIN,
    IAG_OP_POST_DECREMENT_OPERAND,
    IAG_OP_POST_INCREMENT_OPERAND,
    IAG_OP_PRE_INCREMENT_OPERAND,
    IAG_OP_ACCUMULATOR_OFFSET_OPERAND
  } iag_op_t;

  // Decoded file access
  typedef struct packed {
    iag_op_t     op;
    logic [1:0]  pair;
    logic [11:0] addr;
  } iag_decode_t;

  // Extended opcodes made decodable by the extended set
  typedef enum logic [2:0] {
    IAG_X_NONE,
    IAG_X_PTR_ADD,
    IAG_X_CALL_VIA_ACCUMULATOR,
    IAG_X_INDEXED_TO_FILE_MOVE,
    IAG_X_INDEXED_TO_INDEXED_MOVE,
    IAG_X_PTR_SUB
  } iag_xop_t;
endpackage : iag_pkg

// ---- iag_pointer_pair.sv ----
/*
  One pointer pair: twelve-bit pointer with post/pre modify and direct load.
  Assumes strobes come from the core on the same clock, one-cycle pulses.
*/
`timescale 1ns/1ps
`include "iag_defines.svh"

module iag_pointer_pair
  import iag_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        load_low,
  input  wire logic        load_high,
  input  wire logic        load_both,
  input  wire logic [7:0]  wdata,
  input  wire logic        inc,
  input  wire logic        dec,
  output logic      [11:0] ptr
);

  // ==========================================================================
  // Update
  logic [11:0] ptr_q;
  logic [11:0] ptr_d;

  // Whole-pair arithmetic lets low-byte wrap carry into the high byte
  assign ptr_d = load_both ? {4'h0, wdata}
               : load_low  ? {ptr_q[11:8], wdata}
               : load_high ? {wdata[3:0], ptr_q[7:0]}
               : inc       ? ptr_q + `IAG_ONE
               : dec       ? ptr_q - `IAG_ONE
               : ptr_q;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ptr_q <= `IAG_PTR_RESET;
    end else begin
      ptr_q <= ptr_d;
    end
  end

  assign ptr = ptr_q;
endmodule : iag_pointer_pair

// ---- iag_address_gen.sv ----
/*
  Indirect address generator with APB register access.
  Assumes an APB master on the core clock; software writes a file access
  request, the block resolves the data address and runs at most one access on the
  data memory port, which answers in the same cycle.
*/
`timescale 1ns/1ps
`include "iag_defines.svh"

module iag_address_gen
  import iag_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [11:0] mem_addr,
  output logic             mem_rd,
  output logic             mem_wr,
  output logic      [7:0]  mem_wdata,
  input  wire logic [7:0]  mem_rdata,
  input  wire logic [7:0]  flags_in,
  output logic      [7:0]  flags_out
);

  // ==========================================================================
  // Bus decode
  logic        wr_en;
  logic        rd_en;
  logic        hit_access;
  logic        hit_config;
  logic        hit_wreg;
  logic        hit_bank;
  logic        hit_ptr0;
  logic        hit_ptr1;
  logic        hit_ptr2;
  logic        hit_result;
  logic        hit_status;
  logic        hit_opcode;
  logic        hit_any;

  assign wr_en      = psel & penable & pwrite;
  assign rd_en      = psel & penable & ~pwrite;
  assign hit_access = (paddr == `IAG_REG_ACCESS);
  assign hit_config = (paddr == `IAG_REG_CONFIG);
  assign hit_wreg   = (paddr == `IAG_REG_WREG);
  assign hit_bank   = (paddr == `IAG_REG_BANK);
  assign hit_ptr0   = (paddr == `IAG_REG_PTR0);
  assign hit_ptr1   = (paddr == `IAG_REG_PTR1);
  assign hit_ptr2   = (paddr == `IAG_REG_PTR2);
  assign hit_result = (paddr == `IAG_REG_RESULT);
  assign hit_status = (paddr == `IAG_REG_STATUS);
  assign hit_opcode = (paddr == `IAG_REG_OPCODE);
  assign hit_any    = hit_access | hit_config | hit_wreg | hit_bank | hit_ptr0 | hit_ptr1
                    | hit_ptr2 | hit_result | hit_status | hit_opcode;
  assign pready     = 1'b1;
  assign pslverr    = psel & penable & ~hit_any;

  // ==========================================================================
  // Software registers
  logic        extended_set_enable_q;
  logic [7:0]  wreg_q;
  logic [3:0]  bank_q;
  logic [7:0]  result_q;
  logic        last_null_q;
  logic [11:0] last_addr_q;
  logic [7:0]  opcode_q;
  logic        go;
  logic        acc_wr;
  logic        acc_a;
  logic [7:0]  acc_file;
  logic [7:0]  acc_data;

  assign go       = wr_en & hit_access & pwdata[`IAG_ACC_GO_BIT];
  assign acc_wr   = pwdata[`IAG_ACC_WR_BIT];
  assign acc_a    = pwdata[`IAG_ACC_A_BIT];
  assign acc_file = pwdata[7:0];
  assign acc_data = pwdata[23:16];

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      extended_set_enable_q  <= 1'b0;
      wreg_q   <= `IAG_ZERO_BYTE;
      bank_q   <= 4'h0;
      opcode_q <= `IAG_ZERO_BYTE;
    end else begin
      if (wr_en && hit_config) extended_set_enable_q <= pwdata[`IAG_CFG_EXTENDED_SET_ENABLE_BIT];
      if (wr_en && hit_wreg) wreg_q <= pwdata[7:0];
      if (wr_en && hit_bank) bank_q <= pwdata[3:0];
      if (wr_en && hit_opcode) opcode_q <= pwdata[7:0];
    end
  end

  // ==========================================================================
  // File address formation
  logic        lit_mode;
  logic [11:0] direct_addr;
  logic [11:0] ptr [3];
  logic [11:0] file_addr;

  // Literal offset only with the set enabled, access bank and low address
  assign lit_mode    = extended_set_enable_q & ~acc_a & (acc_file <= `IAG_LIT_LIMIT);
  assign direct_addr = acc_a ? {bank_q, acc_file}
                     : (acc_file >= `IAG_ACCESS_SPLIT) ? (`IAG_ACCESS_SFR | {4'h0, acc_file})
                     : {4'h0, acc_file};
  assign file_addr   = lit_mode ? ptr[2] + {4'h0, acc_file} : direct_addr;

  // ==========================================================================
  // Operand decode: pairs sit 8 apart below the pair-zero block
  iag_decode_t dec;
  logic [11:0] rel;
  logic [1:0]  pair_sel;
  logic        in_block;

  assign pair_sel = (file_addr >= `IAG_ADDR_PLUSW0) ? 2'd0
                  : (file_addr >= `IAG_ADDR_PLUSW1) ? 2'd1 : 2'd2;
  assign rel      = file_addr - (`IAG_ADDR_PLUSW0 - `IAG_OPND_SPAN * {10'd0, pair_sel});
  assign in_block = (file_addr >= `IAG_ADDR_PLUSW2) && (rel <= 12'd4)
                  && (file_addr <= `IAG_ADDR_INDIR0);
  always_comb begin
    dec.pair = pair_sel;
    dec.addr = file_addr;
    dec.op   = IAG_OP_NONE;
    if (in_block) begin
      case (rel[2:0])
        3'd0:    dec.op = IAG_OP_ACCUMULATOR_OFFSET_OPERAND;
        3'd1:    dec.op = IAG_OP_PRE_INCREMENT_OPERAND;
        3'd2:    dec.op = IAG_OP_POST_DECREMENT_OPERAND;
        3'd3:    dec.op = IAG_OP_POST_INCREMENT_OPERAND;
        default: dec.op = IAG_OP_PLAIN;
      endcase
    end
  end

  // ==========================================================================
  // Indirect target
  logic [11:0] base;
  logic [11:0] w_ext;
  logic [11:0] ind_addr;
  logic        ind_virtual;
  logic        is_ind;

  assign base   = ptr[dec.pair];
  assign w_ext  = {{4{wreg_q[7]}}, wreg_q};
  assign is_ind = (dec.op != IAG_OP_NONE);
  always_comb begin
    case (dec.op)
      IAG_OP_PRE_INCREMENT_OPERAND: ind_addr = base + `IAG_ONE;
      IAG_OP_ACCUMULATOR_OFFSET_OPERAND:  ind_addr = base + w_ext;
      default:       ind_addr = base;
    endcase
  end
  assign ind_virtual = (ind_addr >= `IAG_ADDR_PLUSW2) && (ind_addr <= `IAG_ADDR_INDIR0)
                     && !(ind_addr >= `IAG_ADDR_PTR1L && ind_addr <= `IAG_ADDR_PTR1H)
                     && !(ind_addr >= `IAG_ADDR_PTR0L && ind_addr <= `IAG_ADDR_PTR0H);

  // Writes aimed at a pair's own operand load the pair directly
  logic self_write;
  assign self_write = go & acc_wr & is_ind;

  // ==========================================================================
  // Pointer pairs
  logic [2:0] p_inc;
  logic [2:0] p_dec;
  logic [2:0] p_lo;
  logic [2:0] p_hi;
  logic [2:0] p_both;
  logic [11:0] lo_addr [3];
  logic [11:0] hi_addr [3];
  assign lo_addr[0] = `IAG_ADDR_PTR0L;
  assign lo_addr[1] = `IAG_ADDR_PTR1L;
  assign lo_addr[2] = `IAG_ADDR_PTR2L;
  assign hi_addr[0] = `IAG_ADDR_PTR0H;
  assign hi_addr[1] = `IAG_ADDR_PTR1H;
  assign hi_addr[2] = `IAG_ADDR_PTR2H;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_pair
      logic [7:0] sw_data;
      logic       sw_hit;
      logic       sel;
      assign sel     = go & is_ind & (dec.pair == 2'(gi));
      // Auto-modify on every pre-increment, post-increment and post-decrement read, virtual targets included; flags are passed through untouched
      assign p_inc[gi]  = sel & ~self_write & (dec.op inside {IAG_OP_POST_INCREMENT_OPERAND, IAG_OP_PRE_INCREMENT_OPERAND});
      assign p_dec[gi]  = sel & ~self_write & (dec.op == IAG_OP_POST_DECREMENT_OPERAND);
      assign p_both[gi] = sel & self_write;
      assign sw_hit  = wr_en & ((gi == 0) ? hit_ptr0 : (gi == 1) ? hit_ptr1 : hit_ptr2);
      assign sw_data = pwdata[7:0];
      // Direct file writes to the pointer bytes, from software or an access
      // A high-byte write must not also load the low byte, which would win the priority
      assign p_lo[gi] = (go & acc_wr & ~is_ind & (file_addr == lo_addr[gi])) | (sw_hit & ~pwdata[31]);
      assign p_hi[gi] = (go & acc_wr & ~is_ind & (file_addr == hi_addr[gi]))
                      | (sw_hit & pwdata[31]);
      iag_pointer_pair u_pair (
        .clock     (clock),
        .rst_n     (rst_n),
        .load_low  (p_lo[gi]),
        .load_high (p_hi[gi]),
        .load_both (p_both[gi]),
        .wdata     (sw_hit ? (pwdata[31] ? pwdata[15:8] : sw_data) : acc_data),
        .inc       (p_inc[gi]),
        .dec       (p_dec[gi]),
        .ptr       (ptr[gi])
      );
    end
  endgenerate

  // ==========================================================================
  // Data memory access
  logic [11:0] tgt_addr;
  logic        blocked;
  logic [7:0]  ptr_byte;
  logic        ptr_read;

  assign tgt_addr  = is_ind ? ind_addr : file_addr;
  assign blocked   = is_ind & ind_virtual;
  assign mem_addr  = tgt_addr;
  assign mem_rd    = go & ~acc_wr & ~blocked & ~ptr_read;
  assign mem_wr    = go & acc_wr & ~blocked & ~self_write & ~(|p_lo) & ~(|p_hi);
  assign mem_wdata = acc_data;
  assign flags_out = flags_in;

  // Pointer bytes read back as themselves for direct access
  assign ptr_read = ~is_ind & ((tgt_addr == `IAG_ADDR_PTR0L) | (tgt_addr == `IAG_ADDR_PTR0H)
                  | (tgt_addr == `IAG_ADDR_PTR1L) | (tgt_addr == `IAG_ADDR_PTR1H)
                  | (tgt_addr == `IAG_ADDR_PTR2L) | (tgt_addr == `IAG_ADDR_PTR2H));
  assign ptr_byte = (tgt_addr == `IAG_ADDR_PTR0L) ? ptr[0][7:0]
                  : (tgt_addr == `IAG_ADDR_PTR0H) ? {4'h0, ptr[0][11:8]}
                  : (tgt_addr == `IAG_ADDR_PTR1L) ? ptr[1][7:0]
                  : (tgt_addr == `IAG_ADDR_PTR1H) ? {4'h0, ptr[1][11:8]}
                  : (tgt_addr == `IAG_ADDR_PTR2L) ? ptr[2][7:0]
                  : {4'h0, ptr[2][11:8]};

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      result_q    <= `IAG_ZERO_BYTE;
      last_null_q <= 1'b0;
      last_addr_q <= `IAG_PTR_RESET;
    end else if (go) begin
      last_null_q <= blocked;
      last_addr_q <= tgt_addr;
      if (!acc_wr) begin
        result_q <= blocked ? `IAG_ZERO_BYTE
                  : ptr_read ? ptr_byte : mem_rdata;
      end
    end
  end

  // ==========================================================================
  // Extended opcode decode: only recognised with the set enabled
  iag_xop_t xop;
  always_comb begin
    xop = IAG_X_NONE;
    if (extended_set_enable_q) begin
      case (opcode_q)
        8'hE8:   xop = IAG_X_PTR_ADD;
        8'h14:   xop = IAG_X_CALL_VIA_ACCUMULATOR;
        8'hEB:   xop = IAG_X_INDEXED_TO_FILE_MOVE;
        8'hEC:   xop = IAG_X_INDEXED_TO_INDEXED_MOVE;
        8'hE9:   xop = IAG_X_PTR_SUB;
        default: xop = IAG_X_NONE;
      endcase
    end
  end

  // ==========================================================================
  // Read mux
  logic [31:0] rdata;
  always_comb begin
    rdata = 32'h0000_0000;
    if (hit_config) rdata = {31'h0000_0000, extended_set_enable_q};
    else if (hit_wreg) rdata = {24'h00_0000, wreg_q};
    else if (hit_bank) rdata = {28'h000_0000, bank_q};
    else if (hit_ptr0) rdata = {20'h0_0000, ptr[0]};
    else if (hit_ptr1) rdata = {20'h0_0000, ptr[1]};
    else if (hit_ptr2) rdata = {20'h0_0000, ptr[2]};
    else if (hit_result) rdata = {24'h00_0000, result_q};
    else if (hit_status) rdata = {19'h0_0000, last_null_q, last_addr_q};
    else if (hit_opcode) rdata = {21'h00_0000, xop, opcode_q};
  end
  // APB read data may be driven straight from the mux since pready is constant high
  assign prdata = rd_en ? rdata : 32'h0000_0000;
endmodule : iag_address_gen

// ---- iag_props.sv ----
/*
  Port checker for iag_address_gen: APB answers, memory strobes, flags.
  Assumes it is bound to the top module; one clock, synchronous reset.
*/
`timescale 1ns/1ps
`include "iag_defines.svh"

module iag_props
  import iag_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [11:0] mem_addr,
  input wire logic        mem_rd,
  input wire logic        mem_wr,
  input wire logic [7:0]  mem_wdata,
  input wire logic [7:0]  mem_rdata,
  input wire logic [7:0]  flags_in,
  input wire logic [7:0]  flags_out
);
  // ==========================================================================
  // Helper logic
  // Shadow of the accumulator, so reads can be tied to the last write
  logic [7:0] w_q;
  logic [7:0] w_d;
  wire        acc_ph = psel && penable;
  wire        go_req = acc_ph && pwrite && paddr == `IAG_REG_ACCESS && pwdata[`IAG_ACC_GO_BIT];
  wire        in_sfr = pwdata[7:0] >= `IAG_ACCESS_SPLIT && pwdata[7:0] < 8'hD9;
  assign w_d = (acc_ph && pwrite && paddr == `IAG_REG_WREG) ? pwdata[7:0] : w_q;
  always_ff @(posedge clock) w_q <= rst_n ? w_d : 8'h00;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_flags_pass: assert property (flags_out == flags_in)
    else $error("flags changed by the block");
  a_read_cause: assert property (mem_rd |-> go_req && !pwdata[`IAG_ACC_WR_BIT])
    else $error("memory read without a read request");
  a_write_cause: assert property (mem_wr |-> go_req && pwdata[`IAG_ACC_WR_BIT] && mem_wdata == pwdata[23:16])
    else $error("memory write without matching request");
  a_strobe_single: assert property ((mem_rd || mem_wr) |=> !(mem_rd || mem_wr))
    else $error("memory strobe longer than one cycle");
  a_direct_upper: assert property (go_req && !pwdata[`IAG_ACC_A_BIT] && in_sfr
    |-> (mem_rd || mem_wr) && mem_addr == {4'hF, pwdata[7:0]})
    else $error("upper access bank address not ordinary");
  a_w_kept: assert property (acc_ph && !pwrite && paddr == `IAG_REG_WREG |-> prdata[7:0] == w_q)
    else $error("accumulator changed");
  a_err_phase: assert property (pslverr |-> acc_ph)
    else $error("slave error outside access phase");
  a_unmapped_err: assert property (acc_ph && (paddr > `IAG_REG_OPCODE || paddr[1:0] != 2'b00) |-> pslverr)
    else $error("unmapped address not refused");
  a_rd_wr_excl: assert property (!(mem_rd && mem_wr))
    else $error("read and write strobes together");

  c_read: cover property (mem_rd);
  c_write: cover property (mem_wr);
  c_refused: cover property (pslverr);
endmodule : iag_props

// ---- test_indirect_address_generator.sv ----
/*
  Self-checking bench for iag_address_gen, driving APB and the memory port.
  Assumes the package, design and iag_props are compiled before it.
*/
`timescale 1ns/1ps
`include "iag_defines.svh"

module test_indirect_address_generator
  import iag_pkg::*;
;
  logic        clock, rst_n, psel, penable, pwrite, pready, pslverr, mem_rd, mem_wr, err;
  logic [11:0] paddr, mem_addr, cap_addr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  mem_wdata, mem_rdata, flags_in, flags_out;
  int          num_errors, check_count, mem_cnt;

  iag_address_gen dut_u (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .flags_in(flags_in), .flags_out(flags_out));

  // ==========================================================================
  // Memory model: data is a fixed function of the address
  function automatic logic [7:0] mdat(input logic [11:0] a);
    return a[7:0] ^ {a[11:8], 4'h5};
  endfunction : mdat
  assign mem_rdata = mdat(mem_addr);
  // Address taken while the strobe stands, before the edge that updates the pointer
  always @* if (mem_rd === 1'b1 || mem_wr === 1'b1) cap_addr = mem_addr;
  always @(posedge clock) if (mem_rd === 1'b1 || mem_wr === 1'b1) mem_cnt <= mem_cnt + 1;

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ==========================================================================
  // Bus and compare tasks
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge clock);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask : chk

  // High byte written with a junk upper nibble; only four bits may stick
  task automatic setp(input int p, input logic [11:0] v);
    apb(1'b1, 12'(`IAG_REG_PTR0 + 4 * p), {24'h00_0000, v[7:0]});
    apb(1'b1, 12'(`IAG_REG_PTR0 + 4 * p), {1'b1, 15'h0000, 4'hA, v[11:8], 8'h00});
  endtask : setp

  task automatic rdp(input int p);
    apb(1'b0, 12'(`IAG_REG_PTR0 + 4 * p), 32'h0000_0000);
  endtask : rdp

  task automatic fac(input logic [7:0] f, input logic w, input logic a, input logic [7:0] d);
    apb(1'b1, `IAG_REG_ACCESS, {8'h00, d, 5'h00, 1'b1, a, w, f});
  endtask : fac

  task automatic result();
    apb(1'b0, `IAG_REG_RESULT, 32'h0000_0000);
  endtask : result

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    for (int p = 0; p < 3; p++) begin
      rdp(p);
      chk("ptr reset", 32'h0000_0000, rd);
    end
    apb(1'b0, `IAG_REG_WREG, 32'h0000_0000);
    chk("w reset", 32'h0000_0000, rd);
    apb(1'b0, 12'h028, 32'h0000_0000);
    chk("unmapped err", 32'h0000_0001, {31'h0, err});
    $display("t_reset done");
  endtask : t_reset

  task automatic t_ops();
    logic [7:0]  ofs[5] = '{8'hEF, 8'hED, 8'hEE, 8'hEC, 8'hEB};
    logic [11:0] st[5]  = '{12'h2A5, 12'h300, 12'h0FF, 12'h1FF, 12'h105};
    logic [11:0] tg[5]  = '{12'h2A5, 12'h300, 12'h0FF, 12'h200, 12'h103};
    logic [11:0] af[5]  = '{12'h2A5, 12'h2FF, 12'h100, 12'h200, 12'h105};
    flags_in <= 8'hA6;
    apb(1'b1, `IAG_REG_WREG, 32'h0000_00FE);
    for (int x = 0; x < 2; x++) begin
      apb(1'b1, `IAG_REG_CONFIG, 32'(x));
      for (int p = 0; p < 2; p++) begin
        for (int i = 0; i < 5; i++) begin
          setp(p, st[i]);
          fac(ofs[i] - 8'(8 * p), 1'b0, 1'b0, 8'h00);
          chk("target", tg[i], cap_addr);
          result();
          chk("read data", mdat(tg[i]), rd[7:0]);
          rdp(p);
          chk("ptr after", af[i], rd[11:0]);
          chk("flags", 8'hA6, flags_out);
        end
      end
    end
    apb(1'b0, `IAG_REG_WREG, 32'h0000_0000);
    chk("w kept", 8'hFE, rd[7:0]);
    apb(1'b1, `IAG_REG_CONFIG, 32'h0000_0000);
    $display("t_ops done");
  endtask : t_ops

  task automatic t_virt();
    int n0;
    setp(1, 12'h123);
    setp(0, `IAG_ADDR_INDIR1);
    n0 = mem_cnt;
    fac(8'hEF, 1'b0, 1'b0, 8'h00);
    result();
    chk("virtual read", 32'h0000_0000, rd[7:0]);
    chk("virtual no strobe", 32'(n0), 32'(mem_cnt));
    fac(8'hEF, 1'b1, 1'b0, 8'h55);
    rdp(1);
    chk("virtual write", 12'h123, rd[11:0]);
    fac(8'hDD, 1'b1, 1'b0, 8'h77);
    rdp(2);
    chk("post_decrement_operand load", 8'h77, rd[7:0]);
    fac(8'hDF, 1'b1, 1'b0, 8'h3C);
    rdp(2);
    chk("plain load", 8'h3C, rd[7:0]);
    fac(8'hE9, 1'b1, 1'b0, 8'h4D);
    rdp(0);
    chk("direct low", 8'h4D, rd[7:0]);
    fac(8'hE9, 1'b0, 1'b0, 8'h00);
    result();
    chk("direct read", 8'h4D, rd[7:0]);
    $display("t_virt done");
  endtask : t_virt

  task automatic t_ext();
    logic        xs[5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
    logic        as[5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
    logic [7:0]  fs[5] = '{8'h10, 8'h10, 8'h5F, 8'h60, 8'h10};
    logic [11:0] es[5] = '{12'h010, 12'h210, 12'h25F, 12'hF60, 12'h310};
    setp(2, 12'h200);
    apb(1'b1, `IAG_REG_BANK, 32'h0000_0003);
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, `IAG_REG_CONFIG, {31'h0, xs[i]});
      fac(fs[i], 1'b0, as[i], 8'h00);
      chk("ext target", es[i], cap_addr);
    end
    $display("t_ext done");
  endtask : t_ext

  // Every opcode is tried; only the set of decoded kinds is judged
  task automatic t_opc();
    logic [7:0] seen;
    for (int x = 0; x < 2; x++) begin
      seen = 8'h00;
      apb(1'b1, `IAG_REG_CONFIG, 32'(x));
      for (int o = 0; o < 256; o++) begin
        apb(1'b1, `IAG_REG_OPCODE, 32'(o));
        apb(1'b0, `IAG_REG_OPCODE, 32'h0000_0000);
        seen[rd[10:8]] = 1'b1;
      end
      chk("decoded kinds", x ? 8'h3F : 8'h01, seen);
    end
    $display("t_opc done");
  endtask : t_opc

  // ==========================================================================
  // Run control
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out

  initial begin
    repeat (50000) @(posedge clock);
    num_errors++;
    close_out();
  end

  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    flags_in = 8'h00;
    cap_addr = 12'h000;
    mem_cnt = 0;
    num_errors = 0;
    check_count = 0;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_ops();
    t_virt();
    t_ext();
    t_opc();
    close_out();
  end
endmodule : test_indirect_address_generator

bind iag_address_gen iag_props props_u (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
  .mem_rdata(mem_rdata), .flags_in(flags_in), .flags_out(flags_out));
